// [rtl/rx_demod_pkg.sv]
package rx_demod_pkg;

    // Register offsets as seen on the serial port
    localparam logic [6:0] GainCfgAddr    = 7'h01;
    localparam logic [6:0] IfChanAddr     = 7'h02;
    localparam logic [6:0] PostFilterAddr = 7'h03;

    // Values after reset
    localparam logic [7:0] GainCfgReset    = 8'h26;  // Release 0x9, mode 0x2
    localparam logic [7:0] IfChanReset     = 8'h00;
    localparam logic [7:0] PostFilterReset = 8'h10;  // Coarse rate 0x2

    // Writable bit masks; reserved bits read as zero
    localparam logic [7:0] GainCfgMask    = 8'h3f;
    localparam logic [7:0] IfChanMask     = 8'h1f;
    localparam logic [7:0] PostFilterMask = 8'hff;

    // Field positions
    localparam int GainModeLsb   = 0;
    localparam int GainRelLsb    = 2;
    localparam int ChanFilterLsb = 0;
    localparam int IfSelBit      = 3;
    localparam int ModSelBit     = 4;
    localparam int FineLsb       = 0;
    localparam int CoarseLsb     = 3;
    localparam int PostBwBit     = 6;
    localparam int LowDelayBit   = 7;

    // Channel filter codes above this one are invalid
    localparam logic [2:0] ChanFilterMax = 3'h4;
    // Coarse code that gives the default rate
    localparam logic [2:0] CoarseDefault = 3'h2;
    // Base of the fine divider, rate = 8/(8+n)
    localparam logic [3:0] FineBase      = 4'h8;
    // Read flag position in the command byte
    localparam int ReadFlagBit           = 7;
    // Last bit index of a serial byte
    localparam logic [2:0] LastBit       = 3'h7;

    // Serial port pins
    typedef struct packed {
        logic csN;
        logic sclk;
        logic mosi;
    } spi_in_type;

    // Settings handed to the demodulation path
    typedef struct packed {
        logic       agcEnable;          // Gain loop running
        logic       adcBackoff;         // ADC buffer backed off
        logic [3:0] gainReleaseThr;     // Release threshold fine tune
        logic       fskMode;            // 1 FSK, 0 ASK
        logic       ifLow;              // 1 200kHz, 0 400kHz
        logic [2:0] channelFilter;      // Last valid filter code
        logic       chanFilterInvalid;  // Stored code is out of range
        logic       lowDelayBuf;        // Low delay output buffer
        logic       postFilterWide;     // 1.67x post filter bandwidth
        logic [1:0] coarseUpShift;      // Rate x 2^up
        logic [2:0] coarseDownShift;    // Rate / 2^down
        logic [3:0] fineDenom;          // Rate x 8/fineDenom
    } rx_ctrl_type;

    typedef enum logic [1:0] {
        FrameIdle = 2'b00,
        FrameCmd  = 2'b01,
        FrameData = 2'b11,
        FrameDone = 2'b10
    } frame_state_type;

endpackage

// [rtl/spi_byte_shifter.sv]
`timescale 1ns/1ps
module spi_byte_shifter (
    // Clock and reset
    input  wire logic                     mclk,
    input  wire logic                     rst,
    // Serial pins
    input  wire rx_demod_pkg::spi_in_type spiIn,
    output logic                          miso,
    // Byte side
    input  wire logic                     txLoad,
    input  wire logic [7:0]               txByte,
    output logic [7:0]                    rxByte,
    output logic                          rxValid
);
    import rx_demod_pkg::*;

    typedef struct packed {
        logic       sclkPrev;   // Last sampled clock pin
        logic [2:0] bitCnt;     // Bits taken in this byte
        logic [7:0] shiftIn;    // Incoming bits
        logic [7:0] shiftOut;   // Outgoing bits
        logic [7:0] rxByte;
        logic       rxValid;
        logic       miso;
    } shifter_state_type;

    shifter_state_type state_q;
    shifter_state_type state_d;

    // Mode 0: sample on rising edge, update output on falling edge
    always_comb begin
        state_d          = state_q;
        state_d.sclkPrev = spiIn.sclk;
        state_d.rxValid  = 1'b0;
        if (spiIn.csN) begin
            // Deselected: realign to a byte boundary
            state_d.bitCnt = 3'h0;
            state_d.miso   = 1'b0;
        end else if (txLoad) begin
            // First bit goes out at once, the rest on falling edges
            state_d.miso     = txByte[7];
            state_d.shiftOut = {txByte[6:0], 1'b0};
        end else if (spiIn.sclk && !state_q.sclkPrev) begin
            state_d.shiftIn = {state_q.shiftIn[6:0], spiIn.mosi};
            state_d.bitCnt  = state_q.bitCnt + 3'h1;
            if (state_q.bitCnt == LastBit) begin
                state_d.rxByte  = {state_q.shiftIn[6:0], spiIn.mosi};
                state_d.rxValid = 1'b1;
            end
        end else if (!spiIn.sclk && state_q.sclkPrev && state_q.bitCnt != 3'h0) begin
            // Skipped at a byte boundary so a fresh load is not disturbed
            state_d.miso     = state_q.shiftOut[7];
            state_d.shiftOut = {state_q.shiftOut[6:0], 1'b0};
        end
    end

    // State register
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign miso    = state_q.miso;
    assign rxByte  = state_q.rxByte;
    assign rxValid = state_q.rxValid;

endmodule // spi_byte_shifter

// [rtl/rx_demod_config_regs.sv]
`timescale 1ns/1ps
// Function
// R01 - Host sets release threshold by data rate
// R02 - Mode field selects gain loop and backoff
// R03 - Bit 4 selects ASK or FSK
// R04 - Bit 3 selects 400kHz or 200kHz IF
// R05 - Channel filter codes 5-7 invalid
// R06 - Host limits low delay buffer use
// R07 - Bandwidth bit widens post filter 1.67x
// R08 - Coarse field scales rate by powers two
// R09 - Fine field scales rate by 8/(8+n)
module rx_demod_config_regs (
    // Clock and reset
    input  wire logic                     mclk,
    input  wire logic                     rst,
    // Serial register port
    input  wire rx_demod_pkg::spi_in_type spiIn,
    output logic                          miso,
    // Settings to the demodulation path
    output rx_demod_pkg::rx_ctrl_type     ctrl
);
    import rx_demod_pkg::*;

    typedef struct packed {
        frame_state_type frame;      // Serial frame position
        logic            isRead;     // Current frame reads
        logic [6:0]      addr;       // Current frame address
        logic            txLoad;     // Load read data into shifter
        logic [7:0]      txByte;     // Read data, registered
        logic [7:0]      gainCfg;    // Gain control register
        logic [7:0]      ifChan;     // IF and channel filter register
        logic [7:0]      postFilter; // Post filter register
        rx_ctrl_type     ctrl;       // Decoded settings
    } regs_state_type;

    regs_state_type state_q;
    regs_state_type state_d;
    logic [7:0]     rxByte;
    logic           rxValid;

    // Read mux, unmapped addresses read as zero
    function automatic logic [7:0] readReg(input logic [6:0] a, input regs_state_type s);
        if (a == GainCfgAddr) begin
            return s.gainCfg;
        end else if (a == IfChanAddr) begin
            return s.ifChan;
        end else if (a == PostFilterAddr) begin
            return s.postFilter;
        end else begin
            return 8'h00;
        end
    endfunction

    // Byte shifter on the serial pins
    spi_byte_shifter u_shifter (
        .mclk    (mclk),
        .rst     (rst),
        .spiIn   (spiIn),
        .miso    (miso),
        .txLoad  (state_q.txLoad),
        .txByte  (state_q.txByte),
        .rxByte  (rxByte),
        .rxValid (rxValid)
    );

    // Frame handling, register writes and settings decode
    always_comb begin
        logic [2:0] coarse;
        logic [2:0] fine;
        logic [2:0] chan;
        logic [1:0] mode;
        coarse         = state_q.postFilter[CoarseLsb +: 3];
        fine           = state_q.postFilter[FineLsb +: 3];
        chan           = state_q.ifChan[ChanFilterLsb +: 3];
        mode           = state_q.gainCfg[GainModeLsb +: 2];
        state_d        = state_q;
        state_d.txLoad = 1'b0;
        case (state_q.frame)
            FrameIdle: begin
                if (!spiIn.csN) begin
                    state_d.frame = FrameCmd;
                end
            end
            FrameCmd: begin
                if (rxValid) begin
                    // Command byte: read flag and address
                    state_d.isRead = rxByte[ReadFlagBit];
                    state_d.addr   = rxByte[6:0];
                    state_d.txByte = readReg(rxByte[6:0], state_q);
                    state_d.txLoad = rxByte[ReadFlagBit];
                    state_d.frame  = FrameData;
                end
            end
            FrameData: begin
                if (rxValid) begin
                    if (!state_q.isRead) begin
                        // Writes to unmapped addresses are dropped
                        if (state_q.addr == GainCfgAddr) begin
                            state_d.gainCfg = rxByte & GainCfgMask;
                        end else if (state_q.addr == IfChanAddr) begin
                            // Invalid filter codes are stored as written
                            state_d.ifChan = rxByte & IfChanMask; // see R05
                        end else if (state_q.addr == PostFilterAddr) begin
                            // Low delay legality is left to the host
                            state_d.postFilter = rxByte & PostFilterMask; // see R06
                        end
                    end
                    state_d.frame = FrameDone;
                end
            end
            FrameDone: begin
                // Extra bytes in the frame are ignored
                state_d.frame = FrameDone;
            end
            default: begin
                state_d.frame = FrameIdle;
            end
        endcase
        if (spiIn.csN) begin
            state_d.frame = FrameIdle;
        end
        // Settings decode, one cycle behind the registers
        state_d.ctrl.agcEnable      = mode[1];                            // see R02
        state_d.ctrl.adcBackoff     = mode[0];                            // see R02
        // Threshold value is whatever the host chose for its data rate
        state_d.ctrl.gainReleaseThr = state_q.gainCfg[GainRelLsb +: 4];   // see R01
        state_d.ctrl.fskMode        = state_q.ifChan[ModSelBit];          // see R03
        state_d.ctrl.ifLow          = state_q.ifChan[IfSelBit];           // see R04
        // An invalid code keeps the filter on its last valid setting
        state_d.ctrl.chanFilterInvalid = chan > ChanFilterMax;            // see R05
        if (chan <= ChanFilterMax) begin
            state_d.ctrl.channelFilter = chan;                            // see R05
        end
        state_d.ctrl.lowDelayBuf    = state_q.postFilter[LowDelayBit];
        state_d.ctrl.postFilterWide = state_q.postFilter[PostBwBit];      // see R07
        // Codes below the default speed up, codes above slow down
        if (coarse < CoarseDefault) begin
            state_d.ctrl.coarseUpShift   = 2'(CoarseDefault - coarse);    // see R08
            state_d.ctrl.coarseDownShift = 3'h0;
        end else begin
            state_d.ctrl.coarseUpShift   = 2'h0;
            state_d.ctrl.coarseDownShift = 3'(coarse - CoarseDefault);    // see R08
        end
        state_d.ctrl.fineDenom = FineBase + {1'b0, fine};                 // see R09
    end

    // State register
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_q            <= '0;
            state_q.gainCfg    <= GainCfgReset;
            state_q.ifChan     <= IfChanReset;
            state_q.postFilter <= PostFilterReset;
            // Decoded settings start out matching the reset register values
            state_q.ctrl.agcEnable      <= GainCfgReset[GainModeLsb + 1];
            state_q.ctrl.adcBackoff     <= GainCfgReset[GainModeLsb];
            state_q.ctrl.gainReleaseThr <= GainCfgReset[GainRelLsb +: 4];
            state_q.ctrl.fineDenom      <= FineBase;
        end else begin
            state_q <= state_d;
        end
    end

    assign ctrl = state_q.ctrl;

    // Gain mode bits drive loop enable and backoff
    property p_gain_mode;
        @(posedge mclk) disable iff (rst)
        ##1 (ctrl.agcEnable == $past(state_q.gainCfg[1]))
            && (ctrl.adcBackoff == $past(state_q.gainCfg[0]));
    endproperty
    a_gain_mode: assert property (p_gain_mode) else $error("gain mode decode wrong"); // see R02

    // Modulation select follows bit 4 after a write
    property p_mod_sel;
        @(posedge mclk) disable iff (rst)
        (state_q.frame == FrameData && rxValid && !state_q.isRead && state_q.addr == IfChanAddr)
        |-> ##2 ctrl.fskMode == $past(rxByte[4], 2);
    endproperty
    a_mod_sel: assert property (p_mod_sel) else $error("modulation select wrong"); // see R03

    // IF select follows bit 3 after a write
    property p_if_sel;
        @(posedge mclk) disable iff (rst)
        (state_q.frame == FrameData && rxValid && !state_q.isRead && state_q.addr == IfChanAddr)
        |-> ##2 ctrl.ifLow == $past(rxByte[3], 2);
    endproperty
    a_if_sel: assert property (p_if_sel) else $error("IF select wrong"); // see R04

    // Filter output never shows an invalid code
    property p_chan_valid;
        @(posedge mclk) disable iff (rst)
        ctrl.channelFilter <= 3'h4;
    endproperty
    a_chan_valid: assert property (p_chan_valid) else $error("filter code above four"); // see R05

    // Invalid code holds the filter and raises the flag
    property p_chan_hold;
        @(posedge mclk) disable iff (rst)
        (state_q.ifChan[2:0] > 3'h4) |=> ctrl.chanFilterInvalid
            && $stable(ctrl.channelFilter);
    endproperty
    a_chan_hold: assert property (p_chan_hold) else $error("invalid filter not held"); // see R05

    // Bandwidth bit reaches the post filter
    property p_post_bw;
        @(posedge mclk) disable iff (rst)
        $rose(state_q.postFilter[6]) |=> ctrl.postFilterWide;
    endproperty
    a_post_bw: assert property (p_post_bw) else $error("post bandwidth not applied"); // see R07

    // Coarse rate: at most one shift direction, total matches code
    property p_coarse;
        @(posedge mclk) disable iff (rst)
        ##1 ($past(state_q.postFilter[5:3]) + {1'b0, ctrl.coarseUpShift}
            == 3'h2 + ctrl.coarseDownShift)
            && (ctrl.coarseUpShift == 2'h0 || ctrl.coarseDownShift == 3'h0);
    endproperty
    a_coarse: assert property (p_coarse) else $error("coarse rate decode wrong"); // see R08

    // Fine denominator is eight plus the code
    property p_fine;
        @(posedge mclk) disable iff (rst)
        ##1 ctrl.fineDenom == 4'h8 + {1'b0, $past(state_q.postFilter[2:0])};
    endproperty
    a_fine: assert property (p_fine) else $error("fine rate decode wrong"); // see R09

    // Main scenarios
    c_write_frame: cover property (@(posedge mclk) disable iff (rst)
        state_q.frame == FrameData && rxValid && !state_q.isRead);
    c_read_frame: cover property (@(posedge mclk) disable iff (rst)
        state_q.txLoad);
    c_invalid_chan: cover property (@(posedge mclk) disable iff (rst)
        ctrl.chanFilterInvalid);
    c_fast_rate: cover property (@(posedge mclk) disable iff (rst)
        ctrl.coarseUpShift == 2'h2);

endmodule // rx_demod_config_regs

// [verif/spi_host_model.sv]
`timescale 1ns/1ps
module spi_host_model (
    // Clock
    input  wire logic               mclk,
    // Serial pins
    output rx_demod_pkg::spi_in_type spiIn,
    input  wire logic               miso
);
    import rx_demod_pkg::*;

    // Idle: deselected, clock parked low as mode 0 wants
    initial begin
        spiIn = '{csN: 1'b1, sclk: 1'b0, mosi: 1'b0};
    end

    // One bit: data set while low, miso taken just before the rise
    task automatic shiftBit(input logic b, output logic got);
        @(posedge mclk) spiIn.mosi <= b;
        // Long low time covers the fall detect plus the miso register
        repeat (6) @(posedge mclk);
        got = miso;
        spiIn.sclk <= 1'b1;
        repeat (3) @(posedge mclk);
        spiIn.sclk <= 1'b0;
    endtask

    // Whole or cut frame, MSB first; n below 16 aborts after n bits
    task automatic frame(input logic [15:0] bits, input int n, output logic [7:0] rd);
        logic g;
        rd = 8'h00;
        @(posedge mclk) spiIn.csN <= 1'b0;
        for (int i = 15; i > 15 - n; i--) begin
            shiftBit(bits[i], g);
            // Second byte carries the read answer
            if (i < 8) begin
                rd[i] = g;
            end
        end
        repeat (2) @(posedge mclk);
        spiIn.csN <= 1'b1;
        // Released line shows the inverse so stale data never matches
        spiIn.mosi <= ~spiIn.mosi;
        repeat (3) @(posedge mclk);
    endtask
endmodule // spi_host_model

// [verif/rx_demod_config_regs_tb.sv]
`timescale 1ns/1ps
module rx_demod_config_regs_tb;
    import rx_demod_pkg::*;

    logic        mclk      = 1'b0;  // Bench clock
    logic        rst       = 1'b1;  // Held at start
    spi_in_type  spiIn;             // Driven by the host model
    logic        miso;              // Read data
    rx_ctrl_type ctrl;              // Decoded settings
    int          fails     = 0;     // Mismatch count
    int          cmp_count = 0;     // Comparison count

    // 50 MHz clock
    always #10 mclk = ~mclk;

    rx_demod_config_regs dut (.mclk(mclk), .rst(rst), .spiIn(spiIn), .miso(miso), .ctrl(ctrl));
    spi_host_model host (.mclk(mclk), .spiIn(spiIn), .miso(miso));

    // Compare and count
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Register write frame
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] x;
        host.frame({1'b0, a, d}, 16, x);
    endtask

    // Register read frame with comparison
    task automatic rdChk(input string what, input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host.frame({1'b1, a, 8'h00}, 16, d);
        check(what, d, exp);
    endtask

    // Counts, verdict, end of run
    task automatic conclude();
        $display("Mismatches %0d of %0d comparisons", fails, cmp_count);
        if (fails == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Watchdog; the tests need about 8000 cycles
    initial begin
        repeat (60000) @(posedge mclk);
        fails++;
        conclude();
    end

    // Main sequence
    initial begin
        logic [3:0] thr;
        logic [7:0] v;
        logic [2:0] last;
        logic [2:0] f;
        logic [2:0] g;
        logic       ld;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        // Values after reset
        rdChk("gainReset", GainCfgAddr, 8'h26);
        rdChk("ifChanReset", IfChanAddr, 8'h00);
        rdChk("postReset", PostFilterAddr, 8'h10);
        // All gain modes, reserved bits written as ones
        for (int m = 0; m < 4; m++) begin
            thr = m[0] ? 4'hf : 4'h9;
            wr(GainCfgAddr, {2'b11, thr, m[1:0]});
            rdChk("gainCfg", GainCfgAddr, {2'b00, thr, m[1:0]});
            check("agcEnable", {7'h00, ctrl.agcEnable}, {7'h00, m[1]});
            check("adcBackoff", {7'h00, ctrl.adcBackoff}, {7'h00, m[0]});
            check("releaseThr", {4'h0, ctrl.gainReleaseThr}, {4'h0, thr});
        end
        // Every filter code, including the invalid ones on purpose
        last = 3'h0;
        for (int c = 0; c < 8; c++) begin
            wr(IfChanAddr, {3'h7, c[0], c[1], c[2:0]});
            rdChk("ifChan", IfChanAddr, {3'h0, c[0], c[1], c[2:0]});
            if (c <= 4) begin
                last = c[2:0];
            end
            check("fskMode", {7'h00, ctrl.fskMode}, {7'h00, c[0]});
            check("ifLow", {7'h00, ctrl.ifLow}, {7'h00, c[1]});
            check("chanFilter", {5'h00, ctrl.channelFilter}, {5'h00, last});
            check("chanInvalid", {7'h00, ctrl.chanFilterInvalid}, 8'(c > 4));
        end
        // Every coarse and fine code; low delay only where legal
        for (int k = 0; k < 8; k++) begin
            g = k[2:0];
            f = 3'(k * 3);
            ld = (g >= 3'h3) || (g == 3'h2 && !f[0]);
            v = {ld, k[0], g, f};
            wr(PostFilterAddr, v);
            rdChk("postFilter", PostFilterAddr, v);
            check("lowDelay", {7'h00, ctrl.lowDelayBuf}, {7'h00, ld});
            check("wideBw", {7'h00, ctrl.postFilterWide}, {7'h00, k[0]});
            check("upShift", {6'h00, ctrl.coarseUpShift}, 8'(g < 2 ? 2 - g : 0));
            check("downShift", {5'h00, ctrl.coarseDownShift}, 8'(g < 2 ? 0 : g - 2));
            check("fineDenom", {4'h0, ctrl.fineDenom}, 8'(8 + f));
        end
        // Unmapped place reads zero, write there is dropped
        rdChk("unmapped", 7'h05, 8'h00);
        wr(7'h05, 8'h00);
        // Aborted frame must not touch the register
        host.frame({1'b0, PostFilterAddr, 8'h00}, 12, v);
        rdChk("postKept", PostFilterAddr, {1'b1, 1'b1, 3'h7, 3'h5});
        // Second reset in mid run
        @(posedge mclk) rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        repeat (3) @(posedge mclk);
        check("rstAgc", {7'h00, ctrl.agcEnable}, 8'h01);
        check("rstThr", {4'h0, ctrl.gainReleaseThr}, 8'h09);
        check("rstFine", {4'h0, ctrl.fineDenom}, 8'h08);
        rdChk("rstPost", PostFilterAddr, 8'h10);
        conclude();
    end
endmodule // rx_demod_config_regs_tb
